// *** rtl/dcrb_device.sv ***
`timescale 1ns/10ps
module dcrb_device (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // link to the controller
  dcrb_link_if.dev_mp link,
  // general-purpose pin
  input wire logic pin_in_i,
  output logic pin_out_o,
  output logic pin_oe_o,
  // channel settings
  output logic [9:0] cur_code_o,
  output logic [9:0] volt_code_o,
  output logic [15:0] range_o,
  output logic [15:0] cmp_setup_o,
  output logic ref_en_o,
  output logic [1:0] pd_volt_o,
  output logic [1:0] pd_cur_o,
  output logic locked_o,
  // action pulses
  output logic load_o,
  output logic clear_o,
  output logic dump_o,
  output logic protect_o,
  output logic dump_read_o,
  output logic store_o,
  output logic reload_o,
  output logic por_o
);
  import dcrb_pkg::*;

  // ==========================================================
  // state
  typedef enum {ST_IDLE, ST_MSB, ST_LSB} dcrb_st_t;
  typedef struct packed {
    logic [15:0] range;
    logic [15:0] cmp;
    logic [9:0] cur;
    logic [9:0] volt;
    logic [15:0] cfg;
    logic [15:0] pin;
  } dcrb_regs_t;
  typedef struct packed {
    dcrb_st_t st;
    logic [7:0] addr;
    logic [7:0] msb;
    dcrb_regs_t rg;
    dcrb_regs_t nv;
    logic nv_prog;
    logic locked;
    logic [15:0] dump;
    logic [7:0] pulse;
    logic por;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic [9:0] cur_out;
    logic pin_out;
    logic pin_oe;
  } dcrb_dev_t;

  localparam dcrb_regs_t REGS_RST = '{range: DATA_RST, cmp: DATA_RST,
    cur: DATA_RST[15:CODE_LSB], volt: DATA_RST[15:CODE_LSB],
    cfg: CFG_RST, pin: PIN_RST};

  dcrb_dev_t q_r, q_nxt;
  logic pin_lvl;
  logic clr_act;

  // ==========================================================
  // read decode
  function automatic logic [15:0] rd_reg(input logic [7:0] a,
      input dcrb_dev_t s);
    logic [15:0] v;
    v = 16'h0000;
    if (a == ADDR_DUMP) begin
      v = s.rg.cfg[CFG_DUMP_RD_DIS] ? 16'h0000 : s.dump;
    end else if (a == ADDR_RANGE) begin
      v = s.rg.range;
    end else if (a == ADDR_CMP) begin
      v = s.rg.cmp;
    end else if (a == ADDR_CUR) begin
      v = {s.rg.cur, 6'h00};
    end else if (a == ADDR_VOLT) begin
      v = {s.rg.volt, 6'h00};
    end else if (a == ADDR_CFG) begin
      v = s.rg.cfg;
      v[CFG_LOCK] = s.locked;
    end else if (a == ADDR_PIN) begin
      v = s.rg.pin;
    end else if (a == ADDR_TRIG) begin
      v = 16'h0000;
    end
    return v;
  endfunction

  // status picked onto the pin in output mode
  function automatic logic stat_bit(input logic [3:0] sel,
      input dcrb_dev_t s, input logic clr);
    logic b;
    b = 1'b0;
    case (sel)
      4'h0: b = s.locked;
      4'h1: b = s.nv_prog;
      4'h2: b = clr;
      4'h3: b = s.por;
      default: b = 1'b0;
    endcase
    return b;
  endfunction

  // ==========================================================
  // pin input path: two-flop sync plus optional filter
  dcrb_pin_filter #(.FILT_CYC(FILTER_CYC)) u_filter (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .pin_i(pin_in_i),
    .filt_en_i(q_r.rg.pin[PIN_FILT_EN]),
    .level_o(pin_lvl)
  );

  // clear is active while the pin input is low, like a comparator
  assign clr_act = q_r.rg.pin[PIN_IN_EN]
    && q_r.rg.pin[PIN_ACT_HI:PIN_ACT_LO] == PIN_ACT_CLEAR
    && q_r.rg.pin[PIN_CH_HI:PIN_CH_LO] == PIN_CH_CUR
    && !pin_lvl;

  // ==========================================================
  // link decode, register writes and triggers
  always_comb begin
    logic [15:0] wd;
    wd = 16'h0000;
    q_nxt = q_r;
    q_nxt.pulse = 8'h00;
    q_nxt.por = 1'b0;
    q_nxt.rsp_valid = 1'b0;
    if (q_r.por) begin
      // soft power-on: restore stored values once programmed
      q_nxt.rg = q_r.nv_prog ? q_r.nv : REGS_RST;
      q_nxt.locked = 1'b0;
      q_nxt.st = ST_IDLE;
    end else if (link.req_valid && link.req_start) begin
      // a new start abandons any half-received frame
      q_nxt.addr = link.req_byte;
      if (link.req_write) begin
        q_nxt.st = ST_MSB;
      end else begin
        q_nxt.st = ST_IDLE;
        q_nxt.rsp_valid = 1'b1;
        q_nxt.rsp_data = rd_reg(link.req_byte, q_r);
      end
    end else if (link.req_valid) begin
      case (q_r.st)
        ST_MSB: begin
          q_nxt.msb = link.req_byte;
          q_nxt.st = ST_LSB;
        end
        ST_LSB: begin
          q_nxt.st = ST_IDLE;
          wd = {q_r.msb, link.req_byte};
          if (q_r.addr == ADDR_TRIG) begin
            if (wd[TRG_UNLK_HI:TRG_UNLK_LO] == UNLOCK_KEY) begin
              q_nxt.locked = 1'b0;
            end
            if (wd[TRG_POR_HI:TRG_POR_LO] == POR_KEY) begin
              q_nxt.por = 1'b1;
            end
            // a locked device honours only unlock and reset keys
            if (!q_r.locked) begin
              q_nxt.pulse = {wd[TRG_LOAD], wd[TRG_CLEAR], wd[TRG_DUMP],
                wd[TRG_PROTECT], wd[TRG_DUMP_RD], wd[TRG_STORE],
                wd[TRG_RELOAD], 1'b0};
              if (wd[TRG_DUMP]) begin
                q_nxt.dump = {q_r.rg.cur, 5'h00, clr_act};
              end
              if (wd[TRG_STORE]) begin
                q_nxt.nv = q_r.rg;
                q_nxt.nv_prog = 1'b1;
              end else if (wd[TRG_RELOAD] && q_r.nv_prog) begin
                q_nxt.rg = q_r.nv;
              end
            end
          end else if (!q_r.locked) begin
            if (q_r.addr == ADDR_RANGE) begin
              q_nxt.rg.range = wd;
            end else if (q_r.addr == ADDR_CMP) begin
              q_nxt.rg.cmp = wd;
            end else if (q_r.addr == ADDR_CUR) begin
              q_nxt.rg.cur = wd[15:CODE_LSB];
            end else if (q_r.addr == ADDR_VOLT) begin
              q_nxt.rg.volt = wd[15:CODE_LSB];
            end else if (q_r.addr == ADDR_CFG) begin
              q_nxt.rg.cfg = wd;
              q_nxt.locked = wd[CFG_LOCK];
            end else if (q_r.addr == ADDR_PIN) begin
              q_nxt.rg.pin = wd;
            end
          end
        end
        default: q_nxt.st = ST_IDLE;
      endcase
    end
    // registered channel and pin outputs
    q_nxt.cur_out = clr_act ? 10'h000 : q_r.rg.cur;
    q_nxt.pin_oe = q_r.rg.pin[PIN_OUT_EN];
    q_nxt.pin_out = stat_bit(q_r.rg.pin[PIN_STAT_HI:PIN_STAT_LO], q_r,
      clr_act);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q_r <= '{st: ST_IDLE, rg: REGS_RST, nv: REGS_RST, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign link.rsp_valid = q_r.rsp_valid;
  assign link.rsp_data = q_r.rsp_data;
  assign pin_out_o = q_r.pin_out;
  assign pin_oe_o = q_r.pin_oe;
  assign cur_code_o = q_r.cur_out;
  assign volt_code_o = q_r.rg.volt;
  assign range_o = q_r.rg.range;
  assign cmp_setup_o = q_r.rg.cmp;
  assign ref_en_o = q_r.rg.cfg[CFG_REF_EN];
  assign pd_volt_o = q_r.rg.cfg[CFG_PDV_HI:CFG_PDV_LO];
  assign pd_cur_o = q_r.rg.cfg[CFG_PDI_HI:CFG_PDI_LO];
  assign locked_o = q_r.locked;
  assign load_o = q_r.pulse[7];
  assign clear_o = q_r.pulse[6];
  assign dump_o = q_r.pulse[5];
  assign protect_o = q_r.pulse[4];
  assign dump_read_o = q_r.pulse[3];
  assign store_o = q_r.pulse[2];
  assign reload_o = q_r.pulse[1];
  assign por_o = q_r.por;
endmodule // dcrb_device

// *** rtl/dcrb_pkg.sv ***
package dcrb_pkg;
  // ==========================================================
  // device register addresses (link address byte)
  localparam logic [7:0] ADDR_DUMP = 8'h00;
  localparam logic [7:0] ADDR_RANGE = 8'h03;
  localparam logic [7:0] ADDR_CMP = 8'h15;
  localparam logic [7:0] ADDR_CUR = 8'h19;
  localparam logic [7:0] ADDR_VOLT = 8'h1c;
  localparam logic [7:0] ADDR_CFG = 8'h1f;
  localparam logic [7:0] ADDR_TRIG = 8'h20;
  localparam logic [7:0] ADDR_PIN = 8'h24;
  // ==========================================================
  // action trigger fields
  localparam int TRG_UNLK_HI = 15;
  localparam int TRG_UNLK_LO = 12;
  localparam logic [3:0] UNLOCK_KEY = 4'h5;
  localparam int TRG_POR_HI = 11;
  localparam int TRG_POR_LO = 8;
  localparam logic [3:0] POR_KEY = 4'ha;
  localparam int TRG_LOAD = 7;
  localparam int TRG_CLEAR = 6;
  localparam int TRG_DUMP = 4;
  localparam int TRG_PROTECT = 3;
  localparam int TRG_DUMP_RD = 2;
  localparam int TRG_STORE = 1;
  localparam int TRG_RELOAD = 0;
  // ==========================================================
  // config fields: lock, dump read disable, power and reference
  localparam int CFG_LOCK = 14;
  localparam int CFG_DUMP_RD_DIS = 13;
  localparam int CFG_REF_EN = 12;
  localparam int CFG_PDV_HI = 11;
  localparam int CFG_PDV_LO = 10;
  localparam int CFG_PDI_HI = 2;
  localparam int CFG_PDI_LO = 1;
  localparam logic [15:0] CFG_RSVD_ONES = 16'h03f9;
  localparam logic [15:0] CFG_RST = 16'h0fff;
  // ==========================================================
  // pin function fields
  localparam int PIN_FILT_EN = 15;
  localparam int PIN_OUT_EN = 13;
  localparam int PIN_STAT_HI = 12;
  localparam int PIN_STAT_LO = 9;
  localparam int PIN_CH_HI = 8;
  localparam int PIN_CH_LO = 5;
  localparam int PIN_ACT_HI = 4;
  localparam int PIN_ACT_LO = 1;
  localparam int PIN_IN_EN = 0;
  localparam logic [3:0] PIN_CH_CUR = 4'h1;
  localparam logic [3:0] PIN_ACT_CLEAR = 4'h7;
  localparam logic [15:0] PIN_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  // left-aligned 10-bit codes sit in [15:6]
  localparam int CODE_LSB = 6;
  // ==========================================================
  // glitch filter time
  localparam int CLK_NS = 10;
  localparam int FILTER_NS = 50;
  localparam int FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // controller registers on AHB-Lite
  localparam logic [31:0] HOST_CMD_OFS = 32'h0000_0000;
  localparam logic [31:0] HOST_STAT_OFS = 32'h0000_0004;
  localparam logic [31:0] HOST_RDATA_OFS = 32'h0000_0008;
  localparam int CMD_WRITE_BIT = 24;
  localparam int CMD_ADDR_LSB = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
endpackage

// *** rtl/dcrb_link_if.sv ***
`timescale 1ns/10ps
// byte link between controller and device, one byte per valid cycle
interface dcrb_link_if;
  logic req_valid;
  logic req_start;
  logic req_write;
  logic [7:0] req_byte;
  logic rsp_valid;
  logic [15:0] rsp_data;
  modport host_mp(output req_valid, output req_start, output req_write,
    output req_byte, input rsp_valid, input rsp_data);
  modport dev_mp(input req_valid, input req_start, input req_write,
    input req_byte, output rsp_valid, output rsp_data);
endinterface

// *** rtl/dcrb_pin_filter.sv ***
`timescale 1ns/10ps
module dcrb_pin_filter #(
  parameter int FILT_CYC = dcrb_pkg::FILTER_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // pin and control
  input wire logic pin_i,
  input wire logic filt_en_i,
  output logic level_o
);
  import dcrb_pkg::*;
  // the counter is eight bits wide, so longer filters are refused
  if (FILT_CYC < 1 || FILT_CYC > 255) begin : g_bad_filt
    $error("filter count out of range");
  end
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic [7:0] cnt;
  } dcrb_flt_t;
  dcrb_flt_t q_r, q_nxt;
  // s1 feeds only s2; the filter needs a level stable for FILT_CYC cycles
  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = pin_i;
    q_nxt.s2 = q_r.s1;
    if (!filt_en_i || q_r.s2 == q_r.lvl) begin
      q_nxt.cnt = 8'h00;
      if (!filt_en_i) q_nxt.lvl = q_r.s2;
    end else if (q_r.cnt == 8'(FILT_CYC - 1)) begin
      q_nxt.lvl = q_r.s2;
      q_nxt.cnt = 8'h00;
    end else begin
      q_nxt.cnt = q_r.cnt + 8'h01;
    end
  end
  // pin idles high so the clear stays off after reset
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) q_r <= '{s1: 1'b1, s2: 1'b1, lvl: 1'b1, cnt: 8'h00};
    else q_r <= q_nxt;
  end
  assign level_o = q_r.lvl;
endmodule // dcrb_pin_filter

// *** rtl/dcrb_host.sv ***
`timescale 1ns/10ps
module dcrb_host (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // link to the device
  dcrb_link_if.host_mp link
);
  import dcrb_pkg::*;

  // ==========================================================
  // state
  typedef enum {H_IDLE, H_MSB, H_LSB, H_WAIT} dcrb_hst_t;
  typedef struct packed {
    dcrb_hst_t st;
    logic ap_wr;
    logic [31:0] ap_addr;
    logic [15:0] data;
    logic done;
    logic [15:0] rdata;
    logic [31:0] hrdata;
    logic req_valid;
    logic req_start;
    logic req_write;
    logic [7:0] req_byte;
  } dcrb_host_t;
  dcrb_host_t q_r, q_nxt;

  // ==========================================================
  // bus decode and link sequencing
  always_comb begin
    logic [7:0] a;
    a = 8'h00;
    q_nxt = q_r;
    q_nxt.req_valid = 1'b0;
    q_nxt.req_start = 1'b0;
    // link sequencer: address, then high byte, then low byte
    case (q_r.st)
      H_MSB: begin
        q_nxt.req_valid = 1'b1;
        q_nxt.req_byte = q_r.data[15:8];
        q_nxt.st = H_LSB;
      end
      H_LSB: begin
        q_nxt.req_valid = 1'b1;
        q_nxt.req_byte = q_r.data[7:0];
        q_nxt.st = H_IDLE;
      end
      H_WAIT: begin
        if (link.rsp_valid) begin
          q_nxt.rdata = link.rsp_data;
          q_nxt.done = 1'b1;
          q_nxt.st = H_IDLE;
        end
      end
      default: q_nxt.st = H_IDLE;
    endcase
    // data phase of a write; commands while busy are dropped
    if (q_r.ap_wr) begin
      if (q_r.ap_addr == HOST_CMD_OFS && q_r.st == H_IDLE) begin
        a = hwdata_i[CMD_ADDR_LSB +: 8];
        // trigger keys and left-aligned codes pass unchanged
        q_nxt.data = hwdata_i[15:0];
        if (a == ADDR_CFG) begin
          q_nxt.data = hwdata_i[15:0] | CFG_RSVD_ONES;
        end
        q_nxt.req_valid = 1'b1;
        q_nxt.req_start = 1'b1;
        q_nxt.req_write = hwdata_i[CMD_WRITE_BIT];
        q_nxt.req_byte = a;
        q_nxt.st = hwdata_i[CMD_WRITE_BIT] ? H_MSB : H_WAIT;
      end else if (q_r.ap_addr == HOST_STAT_OFS) begin
        // a completion in this cycle wins over the clear
        if (hwdata_i[STAT_DONE] && !(q_r.st == H_WAIT && link.rsp_valid)) begin
          q_nxt.done = 1'b0;
        end
      end
    end
    // address phase; read data is taken from the updated state
    q_nxt.ap_wr = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      q_nxt.ap_wr = hwrite_i;
      q_nxt.ap_addr = haddr_i;
      if (!hwrite_i) begin
        if (haddr_i == HOST_STAT_OFS) begin
          q_nxt.hrdata = {30'h0, q_nxt.done, q_nxt.st != H_IDLE};
        end else if (haddr_i == HOST_RDATA_OFS) begin
          q_nxt.hrdata = {16'h0000, q_nxt.rdata};
        end else begin
          q_nxt.hrdata = 32'h0000_0000;
        end
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) q_r <= '{st: H_IDLE, default: '0};
    else q_r <= q_nxt;
  end

  // zero-wait slave: ready and OKAY held constant
  logic ready_r;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) ready_r <= 1'b1;
    else ready_r <= 1'b1;
  end

  // ==========================================================
  // outputs
  assign hrdata_o = q_r.hrdata;
  assign hreadyout_o = ready_r;
  assign hresp_o = q_r.ap_wr & 1'b0;
  assign link.req_valid = q_r.req_valid;
  assign link.req_start = q_r.req_start;
  assign link.req_write = q_r.req_write;
  assign link.req_byte = q_r.req_byte;
endmodule // dcrb_host

// *** tb/dcrb_link_assertions.sv ***
`timescale 1ns/10ps
module dcrb_link_assertions
  import dcrb_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // link signals
  input wire logic req_valid,
  input wire logic req_start,
  input wire logic req_write,
  input wire logic [7:0] req_byte,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================================
  // frame pieces
  sequence s_wr_start;
    req_valid && req_start && req_write;
  endsequence
  sequence s_rd_start;
    req_valid && req_start && !req_write;
  endsequence
  sequence s_data_pair;
    (req_valid && !req_start) [*2];
  endsequence
  // reserved config bits sit in msb[1:0] and lsb mask f9
  sequence s_cfg_bytes;
    (req_byte[1:0] == 2'b11) ##1 ((req_byte & 8'hf9) == 8'hf9);
  endsequence
  // ==========================================================
  // link checks
  a_start_is_valid: assert property (req_start |-> req_valid)
    else $error("start without valid");
  a_write_frame_bytes: assert property (s_wr_start |=> s_data_pair)
    else $error("write frame lacks two data bytes");
  a_read_answer_time: assert property (s_rd_start |=> rsp_valid)
    else $error("read answer late");
  a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  a_rsp_has_cause: assert property (
    rsp_valid |-> $past(req_start) && !$past(req_write))
    else $error("answer without read");
  a_code_low_zero: assert property (rsp_valid &&
    ($past(req_byte) == ADDR_CUR || $past(req_byte) == ADDR_VOLT)
    |-> rsp_data[5:0] == 6'h00)
    else $error("code low bits not zero");
  a_trig_reads_zero: assert property (
    rsp_valid && $past(req_byte) == ADDR_TRIG |-> rsp_data == 16'h0000)
    else $error("trigger reads nonzero");
  a_cfg_rsvd_read: assert property (rsp_valid && $past(req_byte) == ADDR_CFG
    |-> (rsp_data & CFG_RSVD_ONES) == CFG_RSVD_ONES)
    else $error("reserved config bits read zero");
  a_cfg_rsvd_write: assert property (
    s_wr_start and (req_byte == ADDR_CFG) |=> s_cfg_bytes)
    else $error("reserved config bits written zero");
endmodule // dcrb_link_assertions

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  import dcrb_pkg::*;
  logic clock, arst_n, hsel, hwrite, pin_drv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, bus_v;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, pin_out, pin_oe, ref_en, locked, pin_lvl;
  wire logic [1:0] pd_volt, pd_cur;
  wire logic [9:0] cur_code, volt_code;
  wire logic [15:0] range_q, cmp_q;
  wire logic [7:0] pulse;
  int err_count, num_checks, pcnt[8], ecnt[8];
  int seed = 32'hb355;
  logic [15:0] mreg[int], sreg[int], m_dump;
  bit m_lock, m_stored;
  logic [7:0] dtab[4] = '{ADDR_RANGE, ADDR_CMP, ADDR_CUR, ADDR_VOLT};
  dcrb_link_if link();
  // pin wire: own drive wins while output enabled
  assign pin_lvl = pin_oe ? pin_out : pin_drv;
  // ==========================================================
  // clock, design, checker
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  dcrb_host u_dcrb_host (.clock_i(clock), .arst_n_i(arst_n), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .link(link));
  dcrb_device u_dcrb_device (.clock_i(clock), .arst_n_i(arst_n), .link(link),
    .pin_in_i(pin_lvl), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .cur_code_o(cur_code), .volt_code_o(volt_code), .range_o(range_q),
    .cmp_setup_o(cmp_q), .ref_en_o(ref_en), .pd_volt_o(pd_volt),
    .pd_cur_o(pd_cur), .locked_o(locked), .load_o(pulse[7]),
    .clear_o(pulse[6]), .dump_o(pulse[4]), .protect_o(pulse[3]),
    .dump_read_o(pulse[2]), .store_o(pulse[1]), .reload_o(pulse[0]),
    .por_o(pulse[5]));
  dcrb_link_assertions u_chk (.clock_i(clock), .arst_n_i(arst_n),
    .req_valid(link.req_valid), .req_start(link.req_start),
    .req_write(link.req_write), .req_byte(link.req_byte),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));
  // pulses are counted, a doubled pulse shows as a count mismatch
  always @(posedge clock) begin
    for (int i = 0; i < 8; i++) if (pulse[i] === 1'b1) pcnt[i]++;
  end
  // ==========================================================
  // reference model
  function automatic void m_soft();
    if (m_stored) mreg = sreg;
    else begin
      foreach (dtab[i]) mreg[dtab[i]] = DATA_RST;
      mreg[ADDR_CFG] = CFG_RST;
      mreg[ADDR_PIN] = PIN_RST;
    end
    m_lock = 1'b0;
  endfunction
  function automatic void m_hard();
    m_stored = 1'b0;
    m_dump = 16'h0000;
    m_soft();
  endfunction
  function automatic void m_write(input int a, input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (a == ADDR_TRIG) begin
      if (d[15:12] == UNLOCK_KEY) m_lock = 1'b0;
      if (d[11:8] == POR_KEY) begin
        ecnt[5]++;
        m_soft();
      end else if (!m_lock) begin
        for (int i = 2; i < 8; i++) if (d[i] && i != 5) ecnt[i]++;
        if (d[4]) m_dump = {mreg[ADDR_CUR][15:6], 6'h00};
        if (d[0]) ecnt[0]++;
        if (d[1]) begin
          ecnt[1]++;
          sreg = mreg;
          m_stored = 1'b1;
        end else if (d[0] && m_stored) begin
          mreg = sreg;
        end
      end
    end else if (!m_lock && mreg.exists(a)) begin
      if (a == ADDR_CFG) begin
        v = d | CFG_RSVD_ONES;
        m_lock = v[14];
        v[14] = 1'b0;
      end
      if (a == ADDR_CUR || a == ADDR_VOLT) v[5:0] = 6'h00;
      mreg[a] = v;
    end
  endfunction
  function automatic logic [15:0] m_read(input int a);
    if (a == ADDR_CFG) return mreg[a] | {1'b0, m_lock, 14'h0000};
    if (a == ADDR_DUMP) return mreg[ADDR_CFG][13] ? 16'h0000 : m_dump;
    if (mreg.exists(a)) return mreg[a];
    return 16'h0000;
  endfunction
  // ==========================================================
  // bus tasks and compares
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // busy is polled before the next order, a refused order is lost silently
  task automatic dev_cmd(input logic w, input logic [7:0] a, input logic [15:0] d);
    logic [31:0] st;
    int n;
    ahb(1'b1, HOST_STAT_OFS, 32'h0000_0002, st);
    ahb(1'b1, HOST_CMD_OFS, {7'h00, w, a, d}, st);
    n = 0;
    do begin
      ahb(1'b0, HOST_STAT_OFS, 32'h0, st);
      n++;
    end while (st[STAT_BUSY] !== 1'b0 && n < 50);
    chk(st[1:0], {~w, 1'b0});
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    dev_cmd(1'b1, a, d);
    m_write(a, d);
    // low byte lands as busy drops; outputs re-register one edge later
    repeat (2) @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] v;
    dev_cmd(1'b0, a, 16'h0000);
    ahb(1'b0, HOST_RDATA_OFS, 32'h0, v);
    chk(v[15:0], m_read(a));
  endtask
  task automatic pchk();
    for (int i = 0; i < 8; i++) chk(pcnt[i], ecnt[i]);
  endtask
  task automatic ports();
    chk({ref_en, pd_volt, pd_cur}, {mreg[ADDR_CFG][12:10], mreg[ADDR_CFG][2:1]});
    chk({locked, cur_code, volt_code}, {m_lock, mreg[ADDR_CUR][15:6],
      mreg[ADDR_VOLT][15:6]});
    chk({range_q, cmp_q}, {mreg[ADDR_RANGE], mreg[ADDR_CMP]});
  endtask
  task automatic wait_cur(input logic [9:0] e);
    int n;
    n = 0;
    while (cur_code !== e && n < 40) begin
      @(posedge clock);
      n++;
    end
    chk(cur_code, e);
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    pin_drv = 1'b1;
    arst_n = 1'b0;
    m_hard();
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    for (int a = 0; a < 38; a++) rd(8'(a));
    ports();
    for (int i = 0; i < 12; i++) wr(dtab[i % 4], 16'($random(seed)));
    foreach (dtab[i]) rd(dtab[i]);
    ports();
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CFG, 16'($random(seed)) & 16'hbfff);
      rd(ADDR_CFG);
      ports();
    end
    wr(ADDR_CFG, 16'h1000);
    ports();
    for (int i = 2; i < 8; i++) begin
      wr(ADDR_TRIG, 16'h0001 << i);
      rd(ADDR_TRIG);
      rd(ADDR_DUMP);
      pchk();
    end
    wr(ADDR_CFG, 16'h3000);
    rd(ADDR_DUMP);
    // lock drops everything but the keys
    wr(ADDR_CFG, 16'h5000);
    wr(ADDR_CUR, 16'hffc0);
    wr(ADDR_TRIG, 16'h0080);
    rd(ADDR_CUR);
    rd(ADDR_CFG);
    pchk();
    wr(ADDR_TRIG, 16'h5000);
    ports();
    // output mode: status 0 follows lock, status 1 follows store
    wr(ADDR_PIN, 16'h2000);
    wr(ADDR_CFG, 16'h1000 | 16'h4000);
    chk({pin_oe, pin_out}, 2'b11);
    wr(ADDR_TRIG, 16'h5000);
    chk({pin_oe, pin_out}, 2'b10);
    wr(ADDR_PIN, 16'h2200);
    chk({pin_oe, pin_out}, {1'b1, m_stored});
    // pin-driven clear of the current channel
    wr(ADDR_CUR, 16'hb740);
    wr(ADDR_PIN, 16'h002f);
    wait_cur(10'h2dd);
    pin_drv <= 1'b0;
    wait_cur(10'h000);
    rd(ADDR_CUR);
    pin_drv <= 1'b1;
    wait_cur(10'h2dd);
    foreach (dtab[i]) begin
      if (i < 2) wr(ADDR_PIN, i == 0 ? 16'h004f : 16'h002e);
      if (i < 2) pin_drv <= 1'b0;
      repeat (20) @(posedge clock);
      chk(cur_code, 10'h2dd);
      pin_drv <= 1'b1;
    end
    wr(ADDR_PIN, 16'h802f);
    pin_drv <= 1'b0;
    repeat (1 + ($random(seed) & 3)) @(posedge clock);
    pin_drv <= 1'b1;
    repeat (20) @(posedge clock);
    chk(cur_code, 10'h2dd);
    pin_drv <= 1'b0;
    wait_cur(10'h000);
    pin_drv <= 1'b1;
    wait_cur(10'h2dd);
    // store, reload, soft reset, then hard reset loses the store
    wr(ADDR_TRIG, 16'h0002);
    pchk();
    wr(ADDR_CUR, 16'h4d80);
    wr(ADDR_TRIG, 16'h0001);
    rd(ADDR_CUR);
    pchk();
    wr(ADDR_CUR, 16'h4d80);
    wr(ADDR_TRIG, 16'h0a00);
    rd(ADDR_CUR);
    rd(ADDR_PIN);
    pchk();
    ports();
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    m_hard();
    wr(ADDR_TRIG, 16'h0a00);
    rd(ADDR_CUR);
    // reload with nothing stored pulses but leaves the registers
    wr(ADDR_CUR, 16'h4d80);
    wr(ADDR_TRIG, 16'h0001);
    rd(ADDR_CUR);
    pchk();
    ahb(1'b0, 32'h0000_0010, 32'h0, bus_v);
    chk(bus_v, 32'h0);
    chk({hresp, hready}, 2'b01);
    report_and_stop();
  end
  // watchdog far beyond the roughly 1400 cycles the run needs
  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    report_and_stop();
  end
endmodule // testbench
